// File: pmbr_pkg.sv
package pmbr_pkg;

  // ==========================================================
  // Register addresses (management register numbers)
  localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_BASIC_MODE_STATUS = 5'h01;
  localparam logic [4:0] ADDR_PHY_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] ADDR_PHY_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] ADDR_NEGOTIATION_ADVERTISEMENT = 5'h04;

  // ==========================================================
  // Control register fields
  localparam int CTL_RESET = 15;
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_SPEED = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_RESTART_AN = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;
  localparam logic [15:0] CTL_RESET_VALUE = 16'h3100;

  // ==========================================================
  // Status register fields
  localparam logic [15:0] STS_FIXED_CAPS = 16'h7809;
  localparam int STS_PREAMBLE_SUPP = 6;
  localparam int STS_AN_COMPLETE = 5;
  localparam int STS_REMOTE_FAULT = 4;
  localparam int STS_LINK = 2;
  localparam int STS_JABBER = 1;
  localparam logic STS_PREAMBLE_SUPP_RESET = 1'b1;

  // ==========================================================
  // Advertisement register fields
  localparam logic [15:0] ADV_WRITE_MASK = 16'h25FF;
  localparam logic [15:0] ADV_RESET_VALUE = 16'h01E1;
  localparam int ADV_ACK = 14;
  localparam logic [4:0] ADV_SELECTOR_8023 = 5'h01;

  // ==========================================================
  // Identifier field widths
  localparam int OUI_HIGH_W = 16;
  localparam int OUI_LOW_W = 6;
  localparam int MODEL_W = 6;
  localparam int REV_W = 4;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOOPBACK_DEAD_MS = 720;
  localparam int LOOPBACK_DEAD_CYCLES_DEF = LOOPBACK_DEAD_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic we;
    logic re;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pmbr_mgmt_req_t;

  typedef struct packed {
    logic an_complete;
    logic an_speed_100;
    logic an_full_duplex;
    logic an_started;
    logic an_ack;
    logic remote_fault;
    logic link_up;
    logic jabber;
  } pmbr_phy_stat_t;

  typedef enum logic [1:0] {
    PMBR_RUN,
    PMBR_SOFT_RESET
  } pmbr_state_t;

endpackage : pmbr_pkg

// File: pmbr_regs.sv
// Behaviour
// [R1] Writing reset bit restores all defaults; bit reads one until reset done.
// [R2] Loopback bit enables loopback; 100Mbps receive may be dead for 720ms.
// [R3] Speed bit selects 100 or 10; with negotiation reads negotiated speed.
// [R4] Negotiation enabled: speed/duplex report results; disabled: they drive link.
// [R5] Power down bit powers chip down except oscillator; clearing restores.
// [R6] Restart bit re-initiates negotiation, reads one until start; inert if disabled.
// [R7] Clearing restart does not disturb negotiation; keep it cleared when disabled.
// [R8] Duplex bit selects full duplex only when negotiation disabled.
// [R9] Collision test asserts COL for every TX_EN assertion.
// [R10] Reserved control bits read zero, ignore writes; manager writes zeros.
// [R11] Status capability bits fixed: T4 zero, TX/10 full/half, AN, extended one.
// [R12] Preamble suppression bit one accepts preambleless frames; defaults one.
// [R13] Negotiation complete bit reads one once negotiation finished.
// [R14] Remote fault latches high until status read or chip reset.
// [R15] Link status latches low until status read, even if link returns.
// [R16] Jabber latches high until read or reset; only in 10Mbps mode.
// [R17] Identifier registers carry OUI bits 3..18 and 19..24.
// [R18] Second identifier holds model number 9..4 and revision 3..0, fixed.
// [R19] Advertised next page and T4 bits are always zero.
// [R20] Advertised acknowledge is driven by negotiation logic; software never writes.
// [R21] Writable advertisement bits are sent during negotiation with their defaults.
// [R22] Selector defaults to 00001, the 802.3 CSMA/CD code, and is sent.
`timescale 1ns/1ns
`default_nettype none

module pmbr_regs
  import pmbr_pkg::*;
#(
  parameter int LOOPBACK_DEAD_CYCLES = LOOPBACK_DEAD_CYCLES_DEF,
  // Arbitrary identity values
  parameter logic [OUI_HIGH_W-1:0] ORG_ID_UPPER_BITS = 16'h1234,
  parameter logic [OUI_LOW_W-1:0] ORG_ID_LOWER_BITS = 6'h15,
  parameter logic [MODEL_W-1:0] VENDOR_MODEL_NUMBER = 6'h2A,
  parameter logic [REV_W-1:0] MODEL_REVISION = 4'h1
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pmbr_mgmt_req_t i_req,
  input wire pmbr_phy_stat_t i_phy,
  input wire logic i_tx_en,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_loopback,
  output logic o_rx_dead,
  output logic o_power_down,
  output logic o_an_enable,
  output logic o_an_restart,
  output logic o_col,
  output logic o_preamble_suppress,
  output logic o_phy_state_reset,
  output logic [15:0] o_advertisement
);

  // ==========================================================
  // Storage
  logic [15:0] ctl;
  logic [15:0] adv;
  logic preamble_supp;
  logic remote_fault_flag;
  logic link_flag;
  logic jabber_flag;
  logic [15:0] rst_cnt;
  logic [31:0] dead_cnt;
  pmbr_state_t state;

  logic wr_ctl;
  logic wr_sts;
  logic wr_adv;
  logic rd_sts;
  logic soft_rst;
  logic [15:0] status_word;
  logic [15:0] control_word;
  logic [15:0] adv_word;

  assign wr_ctl = i_req.we && i_req.addr == ADDR_BASIC_MODE_CONTROL;
  assign wr_sts = i_req.we && i_req.addr == ADDR_BASIC_MODE_STATUS;
  assign wr_adv = i_req.we && i_req.addr == ADDR_NEGOTIATION_ADVERTISEMENT;
  assign rd_sts = i_req.re && i_req.addr == ADDR_BASIC_MODE_STATUS;
  assign soft_rst = state == PMBR_SOFT_RESET;

  // ==========================================================
  // Soft reset sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= PMBR_RUN;
      rst_cnt <= 16'h0000;
    end
    else
    begin
      case (state)
        PMBR_RUN:
        begin
          if (wr_ctl && i_req.wdata[CTL_RESET]) // [R1]
          begin
            state <= PMBR_SOFT_RESET;
            rst_cnt <= 16'(SOFT_RESET_CYCLES);
          end
        end
        PMBR_SOFT_RESET:
        begin
          if (rst_cnt <= 16'h0001)
            state <= PMBR_RUN;
          rst_cnt <= rst_cnt - 16'h0001;
        end
        default:
          state <= PMBR_RUN;
      endcase
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst)
      ctl <= CTL_RESET_VALUE; // [R1]
    else if (wr_ctl)
    begin
      ctl[CTL_LOOPBACK] <= i_req.wdata[CTL_LOOPBACK]; // [R2]
      ctl[CTL_SPEED] <= i_req.wdata[CTL_SPEED]; // [R3]
      ctl[CTL_AN_ENABLE] <= i_req.wdata[CTL_AN_ENABLE]; // [R4]
      ctl[CTL_POWER_DOWN] <= i_req.wdata[CTL_POWER_DOWN]; // [R5]
      ctl[CTL_DUPLEX] <= i_req.wdata[CTL_DUPLEX]; // [R8]
      ctl[CTL_COL_TEST] <= i_req.wdata[CTL_COL_TEST]; // [R9]
      // Clearing never cancels a pending start; ignored while disabled
      if (i_req.wdata[CTL_RESTART_AN] && i_req.wdata[CTL_AN_ENABLE]) // [R6] [R7]
        ctl[CTL_RESTART_AN] <= 1'b1;
      else if (i_phy.an_started)
        ctl[CTL_RESTART_AN] <= 1'b0;
    end
    else if (i_phy.an_started || !ctl[CTL_AN_ENABLE])
      ctl[CTL_RESTART_AN] <= 1'b0; // [R6]
  end

  // Reserved bits forced to zero on read
  always_comb
  begin
    control_word = 16'h0000; // [R10]
    control_word[CTL_RESET] = soft_rst; // [R1]
    control_word[CTL_LOOPBACK] = ctl[CTL_LOOPBACK];
    control_word[CTL_SPEED] = ctl[CTL_AN_ENABLE] ? i_phy.an_speed_100 : ctl[CTL_SPEED]; // [R3]
    control_word[CTL_AN_ENABLE] = ctl[CTL_AN_ENABLE];
    control_word[CTL_POWER_DOWN] = ctl[CTL_POWER_DOWN];
    control_word[CTL_RESTART_AN] = ctl[CTL_RESTART_AN];
    control_word[CTL_DUPLEX] =
      ctl[CTL_AN_ENABLE] ? i_phy.an_full_duplex : ctl[CTL_DUPLEX]; // [R8]
    control_word[CTL_COL_TEST] = ctl[CTL_COL_TEST];
  end

  // ==========================================================
  // Status register
  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst)
      preamble_supp <= STS_PREAMBLE_SUPP_RESET; // [R12]
    else if (wr_sts)
      preamble_supp <= i_req.wdata[STS_PREAMBLE_SUPP]; // [R12]
  end

  // Event wins over the read-clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst)
      remote_fault_flag <= 1'b0;
    else if (i_phy.remote_fault)
      remote_fault_flag <= 1'b1; // [R14]
    else if (rd_sts)
      remote_fault_flag <= 1'b0; // [R14]
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst)
      jabber_flag <= 1'b0;
    else if (i_phy.jabber && !o_speed_100)
      jabber_flag <= 1'b1; // [R16]
    else if (rd_sts)
      jabber_flag <= 1'b0; // [R16]
  end

  // Latch low: failure wins over the read that would re-arm it
  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst)
      link_flag <= 1'b0;
    else if (!i_phy.link_up)
      link_flag <= 1'b0; // [R15]
    else if (rd_sts)
      link_flag <= 1'b1; // [R15]
  end

  always_comb
  begin
    status_word = STS_FIXED_CAPS; // [R11]
    status_word[STS_PREAMBLE_SUPP] = preamble_supp;
    status_word[STS_AN_COMPLETE] = i_phy.an_complete; // [R13]
    status_word[STS_REMOTE_FAULT] = remote_fault_flag;
    status_word[STS_LINK] = link_flag;
    status_word[STS_JABBER] = jabber_flag;
  end

  // ==========================================================
  // Advertisement register
  always_ff @(posedge i_clk)
  begin
    if (i_rst || soft_rst)
      adv <= ADV_RESET_VALUE; // [R21] [R22]
    else if (wr_adv)
      adv <= i_req.wdata & ADV_WRITE_MASK; // [R19] [R20] [R21]
  end

  always_comb
  begin
    adv_word = adv;
    adv_word[ADV_ACK] = i_phy.an_ack; // [R20]
  end

  // ==========================================================
  // Read port
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_req.re;
      case (i_req.addr)
        ADDR_BASIC_MODE_CONTROL: o_rdata <= control_word;
        ADDR_BASIC_MODE_STATUS: o_rdata <= status_word;
        ADDR_PHY_IDENTIFIER_HIGH: o_rdata <= ORG_ID_UPPER_BITS; // [R17]
        ADDR_PHY_IDENTIFIER_LOW:
          o_rdata <= {ORG_ID_LOWER_BITS, VENDOR_MODEL_NUMBER, MODEL_REVISION}; // [R17] [R18]
        ADDR_NEGOTIATION_ADVERTISEMENT: o_rdata <= adv_word;
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Mode outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_speed_100 <= CTL_RESET_VALUE[CTL_SPEED];
      o_full_duplex <= CTL_RESET_VALUE[CTL_DUPLEX];
      o_loopback <= 1'b0;
      o_power_down <= 1'b0;
      o_an_enable <= CTL_RESET_VALUE[CTL_AN_ENABLE];
      o_an_restart <= 1'b0;
      o_preamble_suppress <= STS_PREAMBLE_SUPP_RESET;
      o_phy_state_reset <= 1'b0;
      o_advertisement <= ADV_RESET_VALUE;
    end
    else
    begin
      o_speed_100 <= control_word[CTL_SPEED]; // [R4]
      o_full_duplex <= control_word[CTL_DUPLEX]; // [R4]
      o_loopback <= ctl[CTL_LOOPBACK]; // [R2]
      o_power_down <= ctl[CTL_POWER_DOWN]; // [R5]
      o_an_enable <= ctl[CTL_AN_ENABLE];
      o_an_restart <= ctl[CTL_RESTART_AN] && ctl[CTL_AN_ENABLE]; // [R6]
      o_preamble_suppress <= preamble_supp; // [R12]
      o_phy_state_reset <= soft_rst; // [R1]
      o_advertisement <= adv_word; // [R21] [R22]
    end
  end

  // ==========================================================
  // Loopback dead time; models descrambler relock at 100Mbps
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dead_cnt <= 32'h00000000;
      o_rx_dead <= 1'b0;
    end
    else
    begin
      if (wr_ctl && i_req.wdata[CTL_LOOPBACK] && !ctl[CTL_LOOPBACK] && o_speed_100)
        dead_cnt <= 32'(LOOPBACK_DEAD_CYCLES); // [R2]
      else if (dead_cnt != 32'h00000000)
        dead_cnt <= dead_cnt - 32'h00000001;
      o_rx_dead <= dead_cnt != 32'h00000000;
    end
  end

  // ==========================================================
  // Collision test: COL follows each TX_EN assertion
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_col <= 1'b0;
    else
      o_col <= ctl[CTL_COL_TEST] && i_tx_en; // [R9]
  end

endmodule : pmbr_regs

`default_nettype wire

// File: pmbr_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pmbr_regs_checker
  import pmbr_pkg::*;
#(
  parameter logic [OUI_HIGH_W-1:0] ORG_ID_UPPER_BITS = 16'h0000,
  parameter logic [OUI_LOW_W-1:0] ORG_ID_LOWER_BITS = 6'h00,
  parameter logic [MODEL_W-1:0] VENDOR_MODEL_NUMBER = 6'h00,
  parameter logic [REV_W-1:0] MODEL_REVISION = 4'h0
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pmbr_mgmt_req_t i_req,
  input wire logic i_tx_en,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_an_enable,
  input wire logic o_an_restart,
  input wire logic o_col,
  input wire logic o_preamble_suppress,
  input wire logic o_phy_state_reset,
  input wire logic [15:0] o_advertisement
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Read answers and fixed advertisement output bits
  AST_ID_HIGH: assert property (i_req.re && i_req.addr == ADDR_PHY_IDENTIFIER_HIGH |=> o_rvalid && o_rdata == ORG_ID_UPPER_BITS)
    else $error("identifier high word wrong");
  AST_ID_LOW: assert property (i_req.re && i_req.addr == ADDR_PHY_IDENTIFIER_LOW |=> o_rdata == {ORG_ID_LOWER_BITS, VENDOR_MODEL_NUMBER, MODEL_REVISION})
    else $error("identifier low word wrong");
  AST_CAPS: assert property (i_req.re && i_req.addr == ADDR_BASIC_MODE_STATUS |=> (o_rdata & 16'hFF89) == 16'h7809)
    else $error("status capability bits wrong");
  AST_PREAMBLE: assert property (i_req.re && i_req.addr == ADDR_BASIC_MODE_STATUS |=> o_rdata[6] == o_preamble_suppress)
    else $error("preamble bit differs from output");
  AST_CTL_RSVD: assert property (i_req.re && i_req.addr == ADDR_BASIC_MODE_CONTROL |=> o_rvalid && o_rdata[10] == 1'b0 && o_rdata[6:0] == 7'h00)
    else $error("reserved control bits not zero");
  AST_ADV_FIXED: assert property (!o_advertisement[15] && !o_advertisement[9])
    else $error("fixed advertisement bits set");
  // ==========================================================
  // Soft reset, restart, collision
  AST_SOFT_START: assert property (i_req.we && i_req.addr == ADDR_BASIC_MODE_CONTROL && i_req.wdata[15] && !o_phy_state_reset |=> ##1 o_phy_state_reset)
    else $error("soft reset did not start");
  AST_SOFT_LEN: assert property ($rose(o_phy_state_reset) |-> o_phy_state_reset[*8] ##1 o_phy_state_reset ##1 o_phy_state_reset ##1 !o_phy_state_reset)
    else $error("soft reset length wrong");
  AST_RESTART: assert property (o_an_restart |-> o_an_enable)
    else $error("restart pending while negotiation off");
  AST_COL_IDLE: assert property (!$past(i_tx_en) |-> !o_col)
    else $error("collision without transmit enable");
  cover property ($rose(o_phy_state_reset));
  cover property (o_col);
  cover property ($fell(o_an_restart));
endmodule : pmbr_regs_checker
bind pmbr_regs pmbr_regs_checker #(.ORG_ID_UPPER_BITS(ORG_ID_UPPER_BITS),
  .ORG_ID_LOWER_BITS(ORG_ID_LOWER_BITS), .VENDOR_MODEL_NUMBER(VENDOR_MODEL_NUMBER),
  .MODEL_REVISION(MODEL_REVISION)) pmbr_regs_checker_inst (.i_clk, .i_rst, .i_req, .i_tx_en,
  .o_rdata, .o_rvalid, .o_an_enable, .o_an_restart, .o_col, .o_preamble_suppress,
  .o_phy_state_reset, .o_advertisement);
`default_nettype wire

// File: pmbr_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmbr_phy_model
  import pmbr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_an_restart,
  input wire logic i_link,
  input wire logic i_fault,
  input wire logic i_jab,
  output pmbr_phy_stat_t o_phy
);
  logic [3:0] cnt;
  logic done;
  // ==========================================================
  // Negotiation starts late so the pending restart is visible
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt <= 4'h0;
      done <= 1'b0;
    end
    else if (i_an_restart || cnt != 4'h0)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h6)
        done <= 1'b0;
      if (cnt == 4'hF)
        done <= 1'b1;
    end
  end
  // Result is 10 Mbps full duplex, unlike the 100 Mbps control default speed
  assign o_phy = '{an_complete: done, an_speed_100: ~done, an_full_duplex: 1'b1,
    an_started: cnt == 4'h6, an_ack: done, remote_fault: i_fault, link_up: i_link,
    jabber: i_jab};
endmodule : pmbr_phy_model
`default_nettype wire

// File: pmbr_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pmbr_regs_bench
  import pmbr_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_tx_en = 1'b0;
  logic link = 1'b1;
  logic fault = 1'b0;
  logic jab = 1'b0;
  pmbr_mgmt_req_t i_req = '0;
  pmbr_phy_stat_t i_phy;
  logic [15:0] o_rdata, o_advertisement, d;
  logic o_rvalid, o_speed_100, o_full_duplex, o_loopback, o_rx_dead, o_power_down;
  logic o_an_enable, o_an_restart, o_col, o_preamble_suppress, o_phy_state_reset;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  pmbr_regs #(.LOOPBACK_DEAD_CYCLES(20)) pmbr_regs_inst (.i_clk, .i_rst, .i_req, .i_phy,
    .i_tx_en, .o_rdata, .o_rvalid, .o_speed_100, .o_full_duplex, .o_loopback, .o_rx_dead,
    .o_power_down, .o_an_enable, .o_an_restart, .o_col, .o_preamble_suppress,
    .o_phy_state_reset, .o_advertisement);
  pmbr_phy_model pmbr_phy_model_inst (.i_clk, .i_rst, .i_an_restart(o_an_restart),
    .i_link(link), .i_fault(fault), .i_jab(jab), .o_phy(i_phy));
  always #50 i_clk = ~i_clk;
  // ==========================================================
  // Hang guard, far above the roughly 160 cycles needed
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // ==========================================================
  // One access; an idle cycle follows so strobes never merge
  task automatic acc(input logic we, input logic [4:0] a, input logic [15:0] wd);
    @(negedge i_clk);
    i_req = '{we: we, re: ~we, addr: a, wdata: wd};
    @(negedge i_clk);
    i_req = '0;
    d = o_rdata;
    if (!we)
      check("rvalid", 16'(o_rvalid), 16'h0001);
  endtask : acc
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
    acc(1'b0, a, 16'h0000);
    check($sformatf("register %0d", a), d & m, exp);
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = ~s;
    @(negedge i_clk);
    s = ~s;
  endtask : pulse
  initial
  begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    rd(5'h00, 16'h3100, 16'hFFFF);
    rd(5'h04, 16'h01E1, 16'hFFFF);
    acc(1'b0, 5'h02, 16'h0000);
    acc(1'b0, 5'h03, 16'h0000);
    rd(5'h05, 16'h0000, 16'hFFFF);
    rd(5'h01, 16'h7849, 16'hFFFF);
    rd(5'h01, 16'h0004, 16'h0004);
    pulse(link);
    rd(5'h01, 16'h0000, 16'h0004);
    rd(5'h01, 16'h0004, 16'h0004);
    pulse(fault);
    rd(5'h01, 16'h0010, 16'h0010);
    rd(5'h01, 16'h0000, 16'h0010);
    pulse(jab);
    rd(5'h01, 16'h0000, 16'h0002);
    acc(1'b1, 5'h00, 16'h1200);
    rd(5'h00, 16'h3300, 16'hFFFF);
    rd(5'h01, 16'h0000, 16'h0020);
    repeat (30) @(negedge i_clk);
    rd(5'h00, 16'h1100, 16'hFFFF);
    rd(5'h01, 16'h0020, 16'h0020);
    check("speed", 16'(o_speed_100), 16'h0000);
    pulse(jab);
    rd(5'h01, 16'h0002, 16'h0002);
    rd(5'h01, 16'h0000, 16'h0002);
    acc(1'b1, 5'h00, 16'h2000);
    @(negedge i_clk);
    check("speed", 16'(o_speed_100), 16'h0001);
    check("duplex", 16'(o_full_duplex), 16'h0000);
    acc(1'b1, 5'h00, 16'h06FF);
    rd(5'h00, 16'h0080, 16'hFFFF);
    i_tx_en = 1'b1;
    @(negedge i_clk);
    check("col", 16'(o_col), 16'h0001);
    i_tx_en = 1'b0;
    @(negedge i_clk);
    check("col", 16'(o_col), 16'h0000);
    acc(1'b1, 5'h00, 16'h2000);
    acc(1'b1, 5'h00, 16'h6000);
    @(negedge i_clk);
    check("loopback", 16'(o_loopback), 16'h0001);
    check("dead", 16'(o_rx_dead), 16'h0001);
    repeat (25) @(negedge i_clk);
    check("dead", 16'(o_rx_dead), 16'h0000);
    acc(1'b1, 5'h00, 16'h0800);
    @(negedge i_clk);
    check("power", 16'(o_power_down), 16'h0001);
    acc(1'b1, 5'h00, 16'h0000);
    @(negedge i_clk);
    check("power", 16'(o_power_down), 16'h0000);
    acc(1'b1, 5'h04, 16'hFFFF);
    rd(5'h04, 16'h65FF, 16'hFFFF);
    check("advert", o_advertisement, 16'h65FF);
    acc(1'b1, 5'h01, 16'h0000);
    rd(5'h01, 16'h0000, 16'h0040);
    acc(1'b1, 5'h00, 16'h8000);
    rd(5'h00, 16'h8000, 16'h8000);
    repeat (15) @(negedge i_clk);
    rd(5'h00, 16'h1100, 16'hFFFF);
    rd(5'h04, 16'h41E1, 16'hFFFF);
    rd(5'h01, 16'h0040, 16'h0040);
    finish_test();
  end
endmodule : pmbr_regs_bench
`default_nettype wire
